/* File: lic_defines.svh */
// Register offsets, command codes, field masks and reset values of the parameter interpreter
`ifndef LIC_DEFINES_SVH
`define LIC_DEFINES_SVH

`define LIC_CMD_SYSSET 8'h40
`define LIC_CMD_MEMWRITE 8'h42
`define LIC_CMD_SCROLL 8'h44
`define LIC_CMD_HSHIFT 8'h5A
`define LIC_CMD_OVERLAY 8'h5B

`define LIC_REG_SYS_CONFIG 5'h00
`define LIC_REG_CHAR_WIDTH 5'h01
`define LIC_REG_CHAR_HEIGHT 5'h02
`define LIC_REG_ADDR_PER_LINE 5'h03
`define LIC_REG_TOTAL_PER_LINE 5'h04
`define LIC_REG_LINES_PER_FRAME 5'h05
`define LIC_REG_VWIDTH_LOW 5'h06
`define LIC_REG_VWIDTH_HIGH 5'h07
`define LIC_REG_BLK1_LOW 5'h0B
`define LIC_REG_BLK1_HIGH 5'h0C
`define LIC_REG_BLK1_LINES 5'h0D
`define LIC_REG_BLK2_LOW 5'h0E
`define LIC_REG_BLK2_HIGH 5'h0F
`define LIC_REG_BLK2_LINES 5'h10
`define LIC_REG_BLK3_LOW 5'h11
`define LIC_REG_BLK3_HIGH 5'h12
`define LIC_REG_BLK4_LOW 5'h13
`define LIC_REG_BLK4_HIGH 5'h14
`define LIC_REG_OVERLAY 5'h18
`define LIC_REG_PIXEL_SHIFT 5'h1B

`define LIC_SYSSET_PARAMS 4'h8
`define LIC_SCROLL_PARAMS 4'hA
`define LIC_IDX_MAX 4'hF

`define LIC_MASK_FULL 8'hFF
`define LIC_MASK_WIDTH 8'h8F
`define LIC_MASK_NIBBLE 8'h0F
`define LIC_MASK_HIGH 8'h7F
`define LIC_MASK_SHIFT 8'h07
`define LIC_MASK_OVERLAY 8'h0F

`define LIC_REG_RESET 8'h00
`define LIC_BUS_IDLE 12'h700
`define LIC_STAT_KNOWN 7

`endif

/* File: lic_pkg.sv */
// Types shared by the parameter interpreter modules
package lic_pkg;

   typedef struct packed {
      logic a0;
      logic rdN;
      logic wrN;
      logic csN;
      logic [7:0] data;
   } lic_bus_t;

   typedef struct packed {
      logic cmdWr;
      logic parWr;
      logic rdActive;
      logic [7:0] data;
   } lic_strobe_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SYSSET = 7'h02,
      ST_SCROLL = 7'h04,
      ST_HSHIFT = 7'h08,
      ST_OVERLAY = 7'h10,
      ST_MEMWRITE = 7'h20,
      ST_OTHER = 7'h40
   } lic_state_t;

   typedef struct packed {
      logic charRomSelect;
      logic charHeightMode;
      logic twoPanelDrive;
      logic topLineComp;
      logic [3:0] charCellWidth;
      logic acDriveSelect;
      logic [3:0] charCellHeight;
      logic [7:0] lineAddressCount;
      logic [7:0] lineTotalCount;
      logic [7:0] frameLineCount;
      logic [14:0] virtualWidth;
      logic [14:0] block1Start;
      logic [7:0] block1Lines;
      logic [14:0] block2Start;
      logic [7:0] block2Lines;
      logic [14:0] block3Start;
      logic [14:0] block4Start;
      logic [2:0] pixelShift;
      logic [1:0] combineMethod;
      logic blockTextSelect;
   } lic_disp_t;

endpackage

/* File: lic_pin_sync.sv */
// Three-stage synchroniser for the host bus pins
`timescale 1ns/100ps
`include "lic_defines.svh"
module lic_pin_sync (
   input wire logic mclk,
   input wire logic rst,
   input wire lic_pkg::lic_bus_t pinsIn,
   output lic_pkg::lic_bus_t pinsStable
);
   logic [11:0] s1_reg, s1_next;
   logic [11:0] s2_reg, s2_next;
   logic [11:0] s3_reg, s3_next;
   logic [11:0] stable_reg, stable_next;

   // Stage one is read only by stage two
   always_comb begin
      s1_next = pinsIn;
      s2_next = s1_reg;
      s3_next = s2_reg;
      // A bit moves only once stages two and three agree
      stable_next = (s2_reg & s3_reg) | (stable_reg & (s2_reg | s3_reg));
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_reg <= `LIC_BUS_IDLE;
         s2_reg <= `LIC_BUS_IDLE;
         s3_reg <= `LIC_BUS_IDLE;
         stable_reg <= `LIC_BUS_IDLE;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         stable_reg <= stable_next;
      end
   end

   assign pinsStable = lic_pkg::lic_bus_t'(stable_reg);
endmodule

/* File: lic_bus_strobe.sv */
// Generic host bus decoder: command and parameter write pulses, read detect
`timescale 1ns/100ps
`include "lic_defines.svh"
module lic_bus_strobe (
   input wire logic mclk,
   input wire logic rst,
   input wire lic_pkg::lic_bus_t busIn,
   output lic_pkg::lic_strobe_t strobe
);
   logic wrActive;
   logic wrEnd;
   logic wrPrev_reg, wrPrev_next;
   logic a0Cap_reg, a0Cap_next;
   logic [7:0] dataCap_reg, dataCap_next;
   logic [7:0] dataHold_reg, dataHold_next;
   logic cmdWr_reg, cmdWr_next;
   logic parWr_reg, parWr_next;

   assign wrActive = !busIn.csN && !busIn.wrN;
   assign wrEnd = wrPrev_reg && !wrActive;

   // Byte taken at the end of the strobe, when data is surely settled
   always_comb begin
      wrPrev_next = wrActive;
      a0Cap_next = wrActive ? busIn.a0 : a0Cap_reg;
      dataCap_next = wrActive ? busIn.data : dataCap_reg;
      dataHold_next = wrEnd ? dataCap_reg : dataHold_reg;
      cmdWr_next = wrEnd && a0Cap_reg;
      parWr_next = wrEnd && !a0Cap_reg;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPrev_reg <= 1'b0;
         a0Cap_reg <= 1'b0;
         dataCap_reg <= 8'h00;
         dataHold_reg <= 8'h00;
         cmdWr_reg <= 1'b0;
         parWr_reg <= 1'b0;
      end else begin
         wrPrev_reg <= wrPrev_next;
         a0Cap_reg <= a0Cap_next;
         dataCap_reg <= dataCap_next;
         dataHold_reg <= dataHold_next;
         cmdWr_reg <= cmdWr_next;
         parWr_reg <= parWr_next;
      end
   end

   assign strobe.cmdWr = cmdWr_reg;
   assign strobe.parWr = parWr_reg;
   assign strobe.rdActive = !busIn.csN && !busIn.rdN && busIn.a0;
   assign strobe.data = dataHold_reg;
endmodule

/* File: lic_params_core.sv */
// Command and parameter interpreter with its internal register file
// Functional notes
// - Setup parameter 1 goes to system configuration: ROM, height mode, panels, compensation.
// - Setup parameter 2: cell width minus one in bits 3-0, AC drive bit 7.
// - Setup parameter 3: cell height minus one in bits 3-0.
// - Setup parameter 4: display addresses per line minus one, full byte.
// - Setup parameter 5: total addresses per line with retrace minus one.
// - Setup parameter 6: display lines per frame minus one.
// - Setup parameters 7 and 8: virtual width, low byte then 7-bit high part.
// - Scroll parameters 1 and 2: block 1 start, low first, 7-bit high.
// - Scroll parameter 3: line count of block 1.
// - Scroll parameters 4-6: block 2 start low, high, then its line count.
// - Scroll parameters 7-10: block 3 then block 4 start, low first.
// - Pixel shift command: one parameter, bits 2-0 give dot offset.
// - Overlay parameter 1: combine method bits 1-0, block 1 text bit 2.
`timescale 1ns/100ps
`include "lic_defines.svh"
module lic_params_core (
   input wire logic mclk,
   input wire logic rst,
   input wire lic_pkg::lic_bus_t busPins,
   output logic [7:0] dataOut,
   output logic dataOutEn,
   output lic_pkg::lic_state_t cmdState,
   output lic_pkg::lic_disp_t dispCfg
);
   lic_pkg::lic_bus_t busStable;
   lic_pkg::lic_strobe_t strobe;
   lic_pkg::lic_state_t state_reg, state_next;
   logic [3:0] idx_reg, idx_next;
   logic [7:0] regs_reg [0:31];
   logic [7:0] regs_next [0:31];
   logic [7:0] dataOut_reg, dataOut_next;
   logic [5:0] target;
   logic [7:0] parData;

   lic_pin_sync uSync (
      .mclk(mclk),
      .rst(rst),
      .pinsIn(busPins),
      .pinsStable(busStable)
   );

   lic_bus_strobe uStrobe (
      .mclk(mclk),
      .rst(rst),
      .busIn(busStable),
      .strobe(strobe)
   );

   assign parData = strobe.data;

   // Hit bit above the register address; unknown slots give no hit
   function automatic logic [5:0] paramTarget(input lic_pkg::lic_state_t st,
                                              input logic [3:0] idx);
      logic [5:0] res;
      res = 6'h00;
      case (st)
         lic_pkg::ST_SYSSET: begin
            if (idx < `LIC_SYSSET_PARAMS) begin
               res = {1'b1, 5'(`LIC_REG_SYS_CONFIG + {1'b0, idx})};
            end
         end
         lic_pkg::ST_SCROLL: begin
            if (idx < `LIC_SCROLL_PARAMS) begin
               res = {1'b1, 5'(`LIC_REG_BLK1_LOW + {1'b0, idx})};
            end
         end
         lic_pkg::ST_HSHIFT: begin
            if (idx == 4'h0) begin
               res = {1'b1, `LIC_REG_PIXEL_SHIFT};
            end
         end
         lic_pkg::ST_OVERLAY: begin
            // Later overlay parameters are not kept
            if (idx == 4'h0) begin
               res = {1'b1, `LIC_REG_OVERLAY};
            end
         end
         default: begin
            res = 6'h00;
         end
      endcase
      return res;
   endfunction

   function automatic logic [7:0] regMask(input logic [4:0] addr);
      logic [7:0] m;
      m = `LIC_MASK_FULL;
      case (addr)
         `LIC_REG_CHAR_WIDTH: m = `LIC_MASK_WIDTH;
         `LIC_REG_CHAR_HEIGHT: m = `LIC_MASK_NIBBLE;
         `LIC_REG_VWIDTH_HIGH: m = `LIC_MASK_HIGH;
         `LIC_REG_BLK1_HIGH: m = `LIC_MASK_HIGH;
         `LIC_REG_BLK2_HIGH: m = `LIC_MASK_HIGH;
         `LIC_REG_BLK3_HIGH: m = `LIC_MASK_HIGH;
         `LIC_REG_BLK4_HIGH: m = `LIC_MASK_HIGH;
         `LIC_REG_PIXEL_SHIFT: m = `LIC_MASK_SHIFT;
         `LIC_REG_OVERLAY: m = `LIC_MASK_OVERLAY;
         default: m = `LIC_MASK_FULL;
      endcase
      return m;
   endfunction

   // Each command restarts the parameter count
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      if (strobe.cmdWr) begin
         idx_next = 4'h0;
         case (strobe.data)
            `LIC_CMD_SYSSET: state_next = lic_pkg::ST_SYSSET;
            `LIC_CMD_SCROLL: state_next = lic_pkg::ST_SCROLL;
            `LIC_CMD_HSHIFT: state_next = lic_pkg::ST_HSHIFT;
            `LIC_CMD_OVERLAY: state_next = lic_pkg::ST_OVERLAY;
            `LIC_CMD_MEMWRITE: state_next = lic_pkg::ST_MEMWRITE;
            default: state_next = lic_pkg::ST_OTHER;
         endcase
      end else if (strobe.parWr && idx_reg != `LIC_IDX_MAX) begin
         // Saturates so a long data stream cannot wrap onto real slots
         idx_next = idx_reg + 4'h1;
      end
   end

   assign target = paramTarget(state_reg, idx_reg);

   always_comb begin
      regs_next = regs_reg;
      if (strobe.parWr && target[5]) begin
         regs_next[target[4:0]] = strobe.data & regMask(target[4:0]);
      end
   end

   // Status: known command in progress and parameter count
   always_comb begin
      dataOut_next = {4'h0, idx_reg};
      dataOut_next[`LIC_STAT_KNOWN] = (state_reg != lic_pkg::ST_IDLE) &&
                                      (state_reg != lic_pkg::ST_OTHER);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= lic_pkg::ST_IDLE;
         idx_reg <= 4'h0;
         dataOut_reg <= 8'h00;
         for (int i = 0; i < 32; i++) begin
            regs_reg[i] <= `LIC_REG_RESET;
         end
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         dataOut_reg <= dataOut_next;
         regs_reg <= regs_next;
      end
   end

   assign dataOut = dataOut_reg;
   assign dataOutEn = strobe.rdActive;
   assign cmdState = state_reg;

   assign dispCfg.charRomSelect = regs_reg[`LIC_REG_SYS_CONFIG][0];
   assign dispCfg.charHeightMode = regs_reg[`LIC_REG_SYS_CONFIG][2];
   assign dispCfg.twoPanelDrive = regs_reg[`LIC_REG_SYS_CONFIG][3];
   assign dispCfg.topLineComp = regs_reg[`LIC_REG_SYS_CONFIG][5];
   assign dispCfg.charCellWidth = regs_reg[`LIC_REG_CHAR_WIDTH][3:0];
   assign dispCfg.acDriveSelect = regs_reg[`LIC_REG_CHAR_WIDTH][7];
   assign dispCfg.charCellHeight = regs_reg[`LIC_REG_CHAR_HEIGHT][3:0];
   assign dispCfg.lineAddressCount = regs_reg[`LIC_REG_ADDR_PER_LINE];
   assign dispCfg.lineTotalCount = regs_reg[`LIC_REG_TOTAL_PER_LINE];
   assign dispCfg.frameLineCount = regs_reg[`LIC_REG_LINES_PER_FRAME];
   assign dispCfg.virtualWidth = {regs_reg[`LIC_REG_VWIDTH_HIGH][6:0],
                                  regs_reg[`LIC_REG_VWIDTH_LOW]};
   assign dispCfg.block1Start = {regs_reg[`LIC_REG_BLK1_HIGH][6:0],
                                 regs_reg[`LIC_REG_BLK1_LOW]};
   assign dispCfg.block1Lines = regs_reg[`LIC_REG_BLK1_LINES];
   assign dispCfg.block2Start = {regs_reg[`LIC_REG_BLK2_HIGH][6:0],
                                 regs_reg[`LIC_REG_BLK2_LOW]};
   assign dispCfg.block2Lines = regs_reg[`LIC_REG_BLK2_LINES];
   assign dispCfg.block3Start = {regs_reg[`LIC_REG_BLK3_HIGH][6:0],
                                 regs_reg[`LIC_REG_BLK3_LOW]};
   assign dispCfg.block4Start = {regs_reg[`LIC_REG_BLK4_HIGH][6:0],
                                 regs_reg[`LIC_REG_BLK4_LOW]};
   assign dispCfg.pixelShift = regs_reg[`LIC_REG_PIXEL_SHIFT][2:0];
   assign dispCfg.combineMethod = regs_reg[`LIC_REG_OVERLAY][1:0];
   assign dispCfg.blockTextSelect = regs_reg[`LIC_REG_OVERLAY][2];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_cfgStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h0
         |=> regs_reg[`LIC_REG_SYS_CONFIG] == $past(parData);
   endproperty
   a_cfgStore: assert property (p_cfgStore) else $error("config byte not stored");

   property p_widthStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h1
         |=> dispCfg.charCellWidth == $past(parData[3:0])
             && dispCfg.acDriveSelect == $past(parData[7]);
   endproperty
   a_widthStore: assert property (p_widthStore) else $error("width byte wrong");

   property p_heightStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h2
         |=> regs_reg[`LIC_REG_CHAR_HEIGHT] == {4'h0, $past(parData[3:0])};
   endproperty
   a_heightStore: assert property (p_heightStore) else $error("height byte wrong");

   property p_lineStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h3
         |=> dispCfg.lineAddressCount == $past(parData);
   endproperty
   a_lineStore: assert property (p_lineStore) else $error("address count wrong");

   property p_totalStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h4
         |=> dispCfg.lineTotalCount == $past(parData);
   endproperty
   a_totalStore: assert property (p_totalStore) else $error("total count wrong");

   property p_frameStore;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h5
         |=> dispCfg.frameLineCount == $past(parData);
   endproperty
   a_frameStore: assert property (p_frameStore) else $error("frame lines wrong");

   property p_vwidthHigh;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h7
         |=> regs_reg[`LIC_REG_VWIDTH_HIGH] == {1'b0, $past(parData[6:0])};
   endproperty
   a_vwidthHigh: assert property (p_vwidthHigh) else $error("virtual width high wrong");

   property p_blk1High;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h1
         |=> dispCfg.block1Start[14:8] == $past(parData[6:0]);
   endproperty
   a_blk1High: assert property (p_blk1High) else $error("block 1 start wrong");

   property p_blk1Lines;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h2
         |=> dispCfg.block1Lines == $past(parData);
   endproperty
   a_blk1Lines: assert property (p_blk1Lines) else $error("block 1 lines wrong");

   property p_blk2Lines;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h5
         |=> dispCfg.block2Lines == $past(parData);
   endproperty
   a_blk2Lines: assert property (p_blk2Lines) else $error("block 2 lines wrong");

   property p_blk4High;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h9
         |=> dispCfg.block4Start[14:8] == $past(parData[6:0]);
   endproperty
   a_blk4High: assert property (p_blk4High) else $error("block 4 start wrong");

   property p_shiftStore;
      strobe.parWr && state_reg == lic_pkg::ST_HSHIFT && idx_reg == 4'h0
         |=> regs_reg[`LIC_REG_PIXEL_SHIFT] == {5'h00, $past(parData[2:0])};
   endproperty
   a_shiftStore: assert property (p_shiftStore) else $error("pixel shift wrong");

   property p_ovlStore;
      strobe.parWr && state_reg == lic_pkg::ST_OVERLAY && idx_reg == 4'h0
         |=> dispCfg.combineMethod == $past(parData[1:0])
             && dispCfg.blockTextSelect == $past(parData[2]);
   endproperty
   a_ovlStore: assert property (p_ovlStore) else $error("overlay byte wrong");

   property p_scrollExtra;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg >= 4'hA
         |=> $stable(regs_reg[`LIC_REG_BLK4_HIGH]) && $stable(regs_reg[`LIC_REG_BLK4_LOW]);
   endproperty
   a_scrollExtra: assert property (p_scrollExtra) else $error("extra parameter stored");

   property p_cmdRestart;
      strobe.cmdWr && strobe.data == `LIC_CMD_SYSSET
         |=> idx_reg == 4'h0 && state_reg == lic_pkg::ST_SYSSET;
   endproperty
   a_cmdRestart: assert property (p_cmdRestart) else $error("command did not restart");

   property p_vwidthLow;
      strobe.parWr && state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h6
         |=> dispCfg.virtualWidth[7:0] == $past(parData);
   endproperty
   a_vwidthLow: assert property (p_vwidthLow) else $error("virtual width low wrong");

   property p_blk2High;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h4
         |=> dispCfg.block2Start[14:8] == $past(parData[6:0]);
   endproperty
   a_blk2High: assert property (p_blk2High) else $error("block 2 start wrong");

   property p_blk3Low;
      strobe.parWr && state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'h6
         |=> dispCfg.block3Start[7:0] == $past(parData);
   endproperty
   a_blk3Low: assert property (p_blk3Low) else $error("block 3 start wrong");

   c_sysDone: cover property (state_reg == lic_pkg::ST_SYSSET && idx_reg == 4'h8);
   c_scrollDone: cover property (state_reg == lic_pkg::ST_SCROLL && idx_reg == 4'hA);
   c_statusRead: cover property (dataOutEn && dataOut[`LIC_STAT_KNOWN]);
   c_ovlSet: cover property (state_reg == lic_pkg::ST_OVERLAY && idx_reg == 4'h1);
endmodule

/* File: lic_host_model.sv */
// Host bus master model driving the parallel command and parameter pins
`timescale 1ns/100ps
`include "lic_defines.svh"
module lic_host_model #(
   parameter int SETTLE_CYCLES = 0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] busData,
   output lic_pkg::lic_bus_t pins
);
   logic [7:0] lastData;

   initial begin
      lastData = 8'hA5;
      pins = '{a0: 1'b0, rdN: 1'b1, wrN: 1'b1, csN: 1'b1, data: 8'h5A};
   end

   task automatic bus_write(input logic isCmd, input logic [7:0] val);
      while (rst) @(posedge mclk);
      @(posedge mclk);
      #1;
      pins.a0 = isCmd;
      pins.data = val;
      pins.csN = 1'b0;
      pins.wrN = 1'b0;
      lastData = val;
      repeat (4) @(posedge mclk);
      #1;
      pins.wrN = 1'b1;
      pins.csN = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      // Undriven bus, no pull: never leave the old byte showing
      pins.data = ~lastData;
      // External oscillator by default, so no settling wait
      if (isCmd && val == `LIC_CMD_SYSSET) repeat (SETTLE_CYCLES) @(posedge mclk);
   endtask

   task automatic bus_read(output logic [7:0] val);
      @(posedge mclk);
      #1;
      pins.a0 = 1'b1;
      pins.csN = 1'b0;
      pins.rdN = 1'b0;
      repeat (6) @(posedge mclk);
      val = busData;
      #1;
      pins.rdN = 1'b1;
      pins.csN = 1'b1;
      // Device drives data until its synchronised read ends; no overlap
      repeat (4) @(posedge mclk);
   endtask
endmodule

/* File: lic_params_core_tb.sv */
// Self-checking bench of the command and parameter interpreter
`timescale 1ns/100ps
`include "lic_defines.svh"
module lic_params_core_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   lic_pkg::lic_bus_t hostPins;
   lic_pkg::lic_bus_t busPins;
   logic [7:0] dataOut;
   logic dataOutEn;
   lic_pkg::lic_state_t cmdState;
   lic_pkg::lic_disp_t dispCfg;
   int fail_count = 0;
   int num_checks = 0;
   integer seed = 32'hDF7C715E;
   logic [7:0] m [0:31];
   logic [6:0] expState;
   int idx;

   always #10 mclk = ~mclk;

   always_comb begin
      busPins = hostPins;
      if (dataOutEn) busPins.data = dataOut;
   end

   // Crystal clocking: settle wait after the setup code
   lic_host_model #(.SETTLE_CYCLES(3)) host (.mclk(mclk), .rst(rst),
      .busData(busPins.data), .pins(hostPins));

   lic_params_core dut (.mclk(mclk), .rst(rst), .busPins(busPins), .dataOut(dataOut),
      .dataOutEn(dataOutEn), .cmdState(cmdState), .dispCfg(dispCfg));

   task automatic test_done();
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] reg_mask(input int a);
      case (a)
         1: return 8'h8F;
         2, 24: return 8'h0F;
         7, 12, 15, 18, 20: return 8'h7F;
         27: return 8'h07;
         default: return 8'hFF;
      endcase
   endfunction

   function automatic lic_pkg::lic_disp_t exp_disp();
      lic_pkg::lic_disp_t d;
      d.charRomSelect = m[0][0];
      d.charHeightMode = m[0][2];
      d.twoPanelDrive = m[0][3];
      d.topLineComp = m[0][5];
      d.charCellWidth = m[1][3:0];
      d.acDriveSelect = m[1][7];
      d.charCellHeight = m[2][3:0];
      d.lineAddressCount = m[3];
      d.lineTotalCount = m[4];
      d.frameLineCount = m[5];
      d.virtualWidth = {m[7][6:0], m[6]};
      d.block1Start = {m[12][6:0], m[11]};
      d.block1Lines = m[13];
      d.block2Start = {m[15][6:0], m[14]};
      d.block2Lines = m[16];
      d.block3Start = {m[18][6:0], m[17]};
      d.block4Start = {m[20][6:0], m[19]};
      d.pixelShift = m[27][2:0];
      d.combineMethod = m[24][1:0];
      d.blockTextSelect = m[24][2];
      return d;
   endfunction

   task automatic model_reset();
      foreach (m[i]) m[i] = 8'h00;
      expState = 7'h01;
      idx = 0;
   endtask

   // Bench model: surplus bytes are dropped, count saturates at 15
   task automatic send(input logic isCmd, input logic [7:0] v);
      int a;
      a = -1;
      host.bus_write(isCmd, v);
      if (isCmd) begin
         idx = 0;
         case (v)
            `LIC_CMD_SYSSET: expState = 7'h02;
            `LIC_CMD_SCROLL: expState = 7'h04;
            `LIC_CMD_HSHIFT: expState = 7'h08;
            `LIC_CMD_OVERLAY: expState = 7'h10;
            `LIC_CMD_MEMWRITE: expState = 7'h20;
            default: expState = 7'h40;
         endcase
      end else begin
         if (expState == 7'h02 && idx < 8) a = idx;
         else if (expState == 7'h04 && idx < 10) a = 11 + idx;
         else if (expState == 7'h08 && idx < 1) a = 27;
         else if (expState == 7'h10 && idx < 1) a = 24;
         if (a >= 0) m[a] = v & reg_mask(a);
         if (idx < 15) idx++;
      end
   endtask

   task automatic verify();
      logic [7:0] st;
      logic known;
      known = expState != 7'h01 && expState != 7'h40;
      repeat (8) @(posedge mclk);
      check("dispCfg", dispCfg, exp_disp());
      check("cmdState", cmdState, expState);
      host.bus_read(st);
      check("dataOutEn", dataOutEn, 1'b1);
      check("status", st, {known, 3'h0, idx[3:0]});
   endtask

   task automatic run_cmd(input logic [7:0] c, input logic [7:0] p [], input int n);
      send(1'b1, c);
      for (int i = 0; i < n; i++) send(1'b0, p[i]);
      verify();
   endtask

   initial begin
      logic [7:0] p [];
      logic [7:0] cmds [0:5];
      int n;
      cmds = '{`LIC_CMD_SYSSET, `LIC_CMD_SCROLL, `LIC_CMD_HSHIFT, `LIC_CMD_OVERLAY,
         `LIC_CMD_MEMWRITE, 8'h4C};
      model_reset();
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
      check("resetCfg", dispCfg, 0);
      check("dataOutEn", dataOutEn, 1'b0);
      verify();
      // Example bring-up values, each followed by one surplus byte
      p = '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h59, 8'h7F, 8'h80, 8'h00, 8'hFF};
      run_cmd(`LIC_CMD_SYSSET, p, 9);
      p = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04, 8'h00, 8'h30, 8'hFF};
      run_cmd(`LIC_CMD_SCROLL, p, 11);
      p = '{8'h00, 8'h07};
      run_cmd(`LIC_CMD_HSHIFT, p, 2);
      p = '{8'h01, 8'hFF};
      run_cmd(`LIC_CMD_OVERLAY, p, 2);
      // Layer clears: text then graphics fill, no register may move
      p = '{8'h20, 8'h20, 8'h20, 8'h20};
      run_cmd(`LIC_CMD_MEMWRITE, p, 4);
      p = '{8'h00, 8'h00, 8'h00};
      run_cmd(`LIC_CMD_MEMWRITE, p, 3);
      // Random commands, lengths past every limit, aborts mid sequence
      for (int k = 0; k < 40; k++) begin
         n = $unsigned($random(seed)) % 18;
         p = new[n];
         foreach (p[i]) p[i] = $random(seed);
         run_cmd(cmds[$unsigned($random(seed)) % 6], p, n);
      end
      // Second reset in mid-run clears everything again
      @(posedge mclk);
      #1;
      rst = 1'b1;
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
      model_reset();
      check("resetCfg", dispCfg, 0);
      verify();
      test_done();
   end

   // Roughly 5000 cycles expected; cut off at 20000
   initial begin
      #400000;
      fail_count++;
      test_done();
   end
endmodule
